// ===== verilog/amrd_defines.svh
`ifndef AMRD_DEFINES_SVH
`define AMRD_DEFINES_SVH

`define AMRD_SRAM_BASE 20'h00000
`define AMRD_SRAM_LAST 20'h01FFF
`define AMRD_SOC_BASE 20'h40000
`define AMRD_SOC_LAST 20'h4FFFF
`define AMRD_ROM_BASE 20'h80000
`define AMRD_ROM_LAST 20'h81FFF
`define AMRD_FLASH_BASE 20'h90000
`define AMRD_FLASH_LAST 20'h9FFFF
`define AMRD_INFO_BASE 20'hD0000
`define AMRD_INFO_LAST 20'hD03FF
`define AMRD_UART_BASE 20'h40E00
`define AMRD_SPI_BASE 20'h40F00
`define AMRD_TWI_BASE 20'h41000
`define AMRD_WIN_SIZE 20'h00100
`define AMRD_P1IC_ADDR 20'h40010
`define AMRD_BOOT_VECTOR 32'h00080000
`define AMRD_P1IC_RESET 16'h0000
`define AMRD_HI_MASK_MSB 31
`define AMRD_HI_MASK_LSB 24
`define AMRD_LO_MASK_MSB 15
`define AMRD_LO_MASK_LSB 8
`define AMRD_FULL_BP_SETS 2
`define AMRD_SIMPLE_BP_REGS 6

`endif

// ===== verilog/amrd_pkg.sv
package amrd_pkg;

  typedef enum logic [2:0] {
    AMRD_SEL_NONE,
    AMRD_SEL_SRAM,
    AMRD_SEL_SOC,
    AMRD_SEL_ROM,
    AMRD_SEL_FLASH,
    AMRD_SEL_INFO
  } amrd_region_t;

  typedef enum logic [1:0] {
    AMRD_PER_OTHER,
    AMRD_PER_UART,
    AMRD_PER_SPI,
    AMRD_PER_TWI
  } amrd_periph_t;

  typedef enum {
    AMRD_OWN_CORE,
    AMRD_OWN_DEBUG
  } amrd_owner_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [19:0] addr;
    logic [31:0] wdata;
    logic [1:0] size;
  } amrd_req_t;

  typedef struct packed {
    logic [15:0] ctrl;
  } amrd_ctrl_t;

endpackage

// ===== verilog/amrd_masked_reg.sv
`timescale 1ns/1ns
`include "amrd_defines.svh"

module amrd_masked_reg #(
  parameter logic [15:0] RESET_VALUE = `AMRD_P1IC_RESET
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic write_in,
  input wire logic [31:0] wdata_in,
  input wire logic [15:0] hw_set_in,
  output logic [15:0] value_out,
  output logic [31:0] rdata_out
);

  logic [15:0] mask;
  logic [15:0] data;

  always_comb begin
    mask = {wdata_in[`AMRD_HI_MASK_MSB:`AMRD_HI_MASK_LSB],
            wdata_in[`AMRD_LO_MASK_MSB:`AMRD_LO_MASK_LSB]}; // see R02
    data = {wdata_in[23:16], wdata_in[7:0]};
  end

  // one-cycle update; hardware set beats a masked clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      value_out <= RESET_VALUE;
    end else if (write_in) begin
      value_out <= ((value_out & ~mask) | (data & mask)) | hw_set_in; // see R03
    end else begin
      value_out <= value_out | hw_set_in;
    end
  end

  // mask lanes read back as zero
  assign rdata_out = {8'h00, value_out[15:8], 8'h00, value_out[7:0]}; // see R16

endmodule

// ===== verilog/amrd_decode.sv
`timescale 1ns/1ns
`include "amrd_defines.svh"

// How it works
// R01: each control register is 32 bits, 16 of them write masks
// R02: mask 31:24 gates bits 23:16, mask 15:8 gates bits 7:0
// R03: a control bit changes only when its paired mask bit is one; the code also sets flag bits 7:0 from synced pin events without a mask
// R04: software writes mask ones with values to touch selected bits
// R05: a full 32-bit register write finishes in one clock; the code ignores register writes while prog_master_in is high
// R06: data sram decoded at 0x0000 through 0x1FFF
// R07: sram takes byte, half and word accesses in one clock
// R08: main program flash decoded at 0x90000 through 0x9FFFF
// R09: boot rom decoded at 0x80000 through 0x81FFF
// R10: after reset the core fetches from the first boot rom address
// R11: peripheral windows decoded at fixed bases, uart spi two-wire
// R12: debug module wins the bus over the core when both request
// R13: debug module offers two full and six simple breakpoint sets
// R14: in normal mode the core cannot reach information flash
// R15: info flash only in development mode, from boot rom or programmer; the code also admits the debug module
// R16: mask positions always read back as zero
module amrd_decode #(
  parameter int FULL_BP_SETS = `AMRD_FULL_BP_SETS,
  parameter int SIMPLE_BP_REGS = `AMRD_SIMPLE_BP_REGS
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire amrd_pkg::amrd_req_t core_req_in,
  input wire amrd_pkg::amrd_req_t debug_req_in,
  input wire logic prog_master_in,
  input wire logic dev_mode_in,
  input wire logic [31:0] core_pc_in,
  input wire logic [7:0] port1_irq_event_in,
  input wire logic [31:0] region_rdata_in,
  output logic [31:0] boot_vector_out,
  output logic core_ready_out,
  output logic debug_ready_out,
  output logic [31:0] rdata_out,
  output logic slverr_out,
  output amrd_pkg::amrd_region_t region_out,
  output amrd_pkg::amrd_periph_t periph_out,
  output logic region_sel_out,
  output logic region_write_out,
  output logic [19:0] region_addr_out,
  output logic [31:0] region_wdata_out,
  output logic [3:0] byte_en_out,
  output logic [7:0] port1_irq_enable_out,
  output logic [7:0] port1_irq_flag_out,
  output logic [3:0] bp_full_sets_out,
  output logic [3:0] bp_simple_regs_out
);

  amrd_pkg::amrd_req_t req;
  amrd_pkg::amrd_owner_t owner;
  amrd_pkg::amrd_region_t region;
  amrd_pkg::amrd_ctrl_t p1ic;
  logic in_boot_rom;
  logic info_ok;
  logic deny;
  logic p1ic_hit;
  logic p1ic_write;
  logic [31:0] p1ic_rdata;
  logic [7:0] irq_meta;
  logic [7:0] irq_sync;

  function automatic logic in_range(input logic [19:0] a,
                                    input logic [19:0] lo,
                                    input logic [19:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_window(input logic [19:0] a,
                                     input logic [19:0] base);
    in_window = (a >= base) && (a < base + `AMRD_WIN_SIZE);
  endfunction

  function automatic logic [3:0] lanes(input logic [1:0] size,
                                       input logic [1:0] low);
    case (size)
      2'h0: lanes = 4'h1 << low;
      2'h1: lanes = low[1] ? 4'hC : 4'h3;
      default: lanes = 4'hF;
    endcase
  endfunction

  assign boot_vector_out = `AMRD_BOOT_VECTOR; // see R10
  assign bp_full_sets_out = 4'(FULL_BP_SETS); // see R13
  assign bp_simple_regs_out = 4'(SIMPLE_BP_REGS); // see R13

  // debug master is fixed top priority; core waits while it holds the bus
  always_comb begin
    if (debug_req_in.sel) begin
      owner = amrd_pkg::AMRD_OWN_DEBUG; // see R12
      req = debug_req_in;
    end else begin
      owner = amrd_pkg::AMRD_OWN_CORE;
      req = core_req_in;
    end
  end

  always_comb begin
    if (in_range(req.addr, `AMRD_SRAM_BASE, `AMRD_SRAM_LAST)) begin
      region = amrd_pkg::AMRD_SEL_SRAM; // see R06
    end else if (in_range(req.addr, `AMRD_SOC_BASE, `AMRD_SOC_LAST)) begin
      region = amrd_pkg::AMRD_SEL_SOC;
    end else if (in_range(req.addr, `AMRD_ROM_BASE, `AMRD_ROM_LAST)) begin
      region = amrd_pkg::AMRD_SEL_ROM; // see R09
    end else if (in_range(req.addr, `AMRD_FLASH_BASE,
                          `AMRD_FLASH_LAST)) begin
      region = amrd_pkg::AMRD_SEL_FLASH; // see R08
    end else if (in_range(req.addr, `AMRD_INFO_BASE, `AMRD_INFO_LAST)) begin
      region = amrd_pkg::AMRD_SEL_INFO;
    end else begin
      region = amrd_pkg::AMRD_SEL_NONE;
    end
  end

  always_comb begin
    if (in_window(req.addr, `AMRD_UART_BASE)) begin
      periph_out = amrd_pkg::AMRD_PER_UART; // see R11
    end else if (in_window(req.addr, `AMRD_SPI_BASE)) begin
      periph_out = amrd_pkg::AMRD_PER_SPI; // see R11
    end else if (in_window(req.addr, `AMRD_TWI_BASE)) begin
      periph_out = amrd_pkg::AMRD_PER_TWI; // see R11
    end else begin
      periph_out = amrd_pkg::AMRD_PER_OTHER;
    end
  end

  // the core counts as boot code only while its pc sits in boot rom
  assign in_boot_rom = in_range(core_pc_in[19:0], `AMRD_ROM_BASE,
                                `AMRD_ROM_LAST) &&
                       (core_pc_in[31:20] == 12'h000);
  // debug module holding the bus is a development path as well
  assign info_ok = dev_mode_in &&
                   (prog_master_in ||
                    owner == amrd_pkg::AMRD_OWN_DEBUG ||
                    in_boot_rom); // see R15
  assign deny = (region == amrd_pkg::AMRD_SEL_INFO) && !info_ok; // see R14

  assign p1ic_hit = req.addr == `AMRD_P1IC_ADDR;
  assign p1ic_write = req.sel && req.enable && req.write && p1ic_hit &&
                      !prog_master_in; // see R05

  // port pin events are asynchronous; two flops before the flags see them
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      irq_meta <= 8'h00;
      irq_sync <= 8'h00;
    end else begin
      irq_meta <= port1_irq_event_in;
      irq_sync <= irq_meta;
    end
  end

  amrd_masked_reg #(
    .RESET_VALUE(`AMRD_P1IC_RESET)
  ) u_port1_interrupt_control (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .write_in(p1ic_write),
    .wdata_in(req.wdata),
    .hw_set_in({8'h00, irq_sync}),
    .value_out(p1ic.ctrl),
    .rdata_out(p1ic_rdata)
  ); // see R01

  assign port1_irq_enable_out = p1ic.ctrl[15:8];
  assign port1_irq_flag_out = p1ic.ctrl[7:0];

  // single access phase: ready the same cycle, no wait states
  always_comb begin
    core_ready_out = (owner == amrd_pkg::AMRD_OWN_CORE) &&
                     core_req_in.enable; // see R07
    debug_ready_out = (owner == amrd_pkg::AMRD_OWN_DEBUG) &&
                      debug_req_in.enable;
  end

  // the downstream select is gated when info flash is refused; the write strobe is not
  always_comb begin
    region_out = deny ? amrd_pkg::AMRD_SEL_NONE : region;
    region_sel_out = req.sel && !deny &&
                     region != amrd_pkg::AMRD_SEL_NONE && !p1ic_hit;
    region_write_out = req.write &&
                       region != amrd_pkg::AMRD_SEL_ROM;
    region_addr_out = req.addr;
    region_wdata_out = req.wdata;
    byte_en_out = lanes(req.size, req.addr[1:0]); // see R07
  end

  // registered read data: captured on the setup phase
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= 32'h00000000;
    end else if (req.sel && !req.enable && !req.write) begin
      if (deny || region == amrd_pkg::AMRD_SEL_NONE) begin
        rdata_out <= 32'h00000000;
      end else if (p1ic_hit) begin
        rdata_out <= p1ic_rdata; // see R16
      end else begin
        rdata_out <= region_rdata_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      slverr_out <= 1'b0;
    end else if (req.sel && !req.enable) begin
      slverr_out <= deny || region == amrd_pkg::AMRD_SEL_NONE; // see R14
    end
  end

endmodule

// ===== verification/amrd_checker.sv
`timescale 1ns/1ns
module amrd_checker (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire amrd_pkg::amrd_req_t core_req_in,
  input wire amrd_pkg::amrd_req_t debug_req_in,
  input wire logic prog_master_in,
  input wire logic dev_mode_in,
  input wire logic [7:0] port1_irq_event_in,
  input wire logic [31:0] boot_vector_out,
  input wire logic core_ready_out,
  input wire logic debug_ready_out,
  input wire logic [31:0] rdata_out,
  input wire logic slverr_out,
  input wire amrd_pkg::amrd_region_t region_out,
  input wire amrd_pkg::amrd_periph_t periph_out,
  input wire logic [7:0] port1_irq_enable_out,
  input wire logic [7:0] port1_irq_flag_out,
  input wire logic [3:0] bp_full_sets_out,
  input wire logic [3:0] bp_simple_regs_out,
  input wire logic region_sel_out,
  input wire logic region_write_out,
  input wire logic [19:0] region_addr_out,
  input wire logic [31:0] region_wdata_out,
  input wire logic [3:0] byte_en_out
);
  amrd_pkg::amrd_req_t q;
  logic [19:0] a;
  logic [7:0] m_hi, v_hi, m_lo, v_lo;
  logic wr_reg, rd_setup;
  // debug request owns the bus whenever its select is up
  assign q = debug_req_in.sel ? debug_req_in : core_req_in;
  assign a = q.addr;
  assign {m_hi, v_hi, m_lo, v_lo} = q.wdata;
  assign wr_reg = q.sel && q.enable && q.write && a == 20'h40010 &&
    !prog_master_in;
  assign rd_setup = q.sel && !q.enable && !q.write;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_boot_vector: assert property (boot_vector_out == 32'h00080000)
    else $error("boot vector wrong");
  a_bp_counts: assert property (bp_full_sets_out == 4'h2 &&
    bp_simple_regs_out == 4'h6) else $error("breakpoint counts wrong");
  a_sram_map: assert property (q.sel && a <= 20'h01FFF |->
    region_out == amrd_pkg::AMRD_SEL_SRAM) else $error("sram decode");
  a_rom_map: assert property (q.sel && a[19:13] == 7'h40 |->
    region_out == amrd_pkg::AMRD_SEL_ROM) else $error("rom decode");
  a_flash_map: assert property (q.sel && a[19:16] == 4'h9 |->
    region_out == amrd_pkg::AMRD_SEL_FLASH) else $error("flash decode");
  a_uart_window: assert property (q.sel && a[19:8] == 12'h40E |->
    periph_out == amrd_pkg::AMRD_PER_UART) else $error("uart window");
  a_debug_first: assert property (debug_req_in.sel &&
    debug_req_in.enable |-> debug_ready_out && !core_ready_out)
    else $error("debug not granted first");
  a_one_cycle: assert property (q.sel && q.enable |->
    core_ready_out || debug_ready_out) else $error("access stalled");
  a_info_denied: assert property (rd_setup && a[19:10] == 10'h340 &&
    !dev_mode_in |=> slverr_out && rdata_out == 32'h00000000)
    else $error("info flash reachable");
  a_masked_hi: assert property (wr_reg |=>
    port1_irq_enable_out == (($past(port1_irq_enable_out) & ~$past(m_hi))
    | ($past(v_hi) & $past(m_hi)))) else $error("high half mask");
  a_masked_lo: assert property (wr_reg &&
    $past(port1_irq_event_in, 2) == 8'h00 |=>
    port1_irq_flag_out == (($past(port1_irq_flag_out) & ~$past(m_lo))
    | ($past(v_lo) & $past(m_lo)))) else $error("low half mask");
  a_mask_zero: assert property (rd_setup && a == 20'h40010 |=>
    rdata_out[31:24] == 8'h00 && rdata_out[15:8] == 8'h00 &&
    rdata_out[23:16] == port1_irq_enable_out) else $error("mask readback");
  a_byte_lanes: assert property (q.sel |-> byte_en_out ==
    (q.size == 2'h0 ? 4'h1 << a[1:0] :
    (q.size == 2'h1 ? (a[1] ? 4'hC : 4'h3) : 4'hF)))
    else $error("byte lanes wrong");
  a_info_gated: assert property (q.sel && a[19:10] == 10'h340 &&
    !dev_mode_in |-> !region_sel_out &&
    region_out == amrd_pkg::AMRD_SEL_NONE) else $error("info strobe open");
  a_rom_readonly: assert property (q.write &&
    a[19:13] == 7'h40 |-> !region_write_out) else $error("rom written");
  a_path_forward: assert property (region_addr_out == a &&
    region_wdata_out == q.wdata) else $error("request not forwarded");
endmodule

bind amrd_decode amrd_checker amrd_checker_inst (.*);

// ===== verification/amrd_master.sv
`timescale 1ns/1ns
module amrd_master (
  input wire logic clk_in,
  input wire logic ready_in,
  output amrd_pkg::amrd_req_t req_out
);
  int late = 0;
  logic [1:0] size = 2'h2;
  initial req_out = '0;
  // setup, then access held until ready is sampled high or 16 clocks pass
  task automatic xfer(input logic wr, input logic [19:0] a,
                      input logic [31:0] d);
    int n;
    @(negedge clk_in);
    req_out = '{1'b1, 1'b0, wr, a, d, size};
    @(negedge clk_in);
    req_out.enable = 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (!ready_in && n < 16);
    if (!ready_in) late++;
    @(negedge clk_in);
    // released lines show the inverse write, address and data, never a stale match
    req_out = '{1'b0, 1'b0, ~wr, ~a, ~d, 2'h1};
  endtask
endmodule

// ===== verification/amrd_decode_tb_top.sv
`timescale 1ns/1ns
module amrd_decode_tb_top;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  amrd_pkg::amrd_req_t core_req_in, debug_req_in;
  logic prog_master_in = 1'b0;
  logic dev_mode_in = 1'b0;
  logic [31:0] core_pc_in = 32'h00090000;
  logic [7:0] port1_irq_event_in = 8'h00;
  logic [31:0] region_rdata_in = 32'h00000000;
  logic [31:0] boot_vector_out, rdata_out;
  logic core_ready_out, debug_ready_out, slverr_out;
  logic [3:0] bp_full_sets_out, bp_simple_regs_out;
  int errors = 0;
  int samples_checked = 0;
  int seed = 44943;
  logic [15:0] model = 16'h0000;
  logic [19:0] addrs [8] = '{20'h00000, 20'h01FFF, 20'h80000, 20'h81FFF,
    20'h90000, 20'h9FFFF, 20'h40E00, 20'h02000};

  always #25 clk_in = ~clk_in;

  amrd_master core_master_inst (.clk_in, .ready_in(core_ready_out),
    .req_out(core_req_in));
  amrd_master debug_master_inst (.clk_in, .ready_in(debug_ready_out),
    .req_out(debug_req_in));
  amrd_decode amrd_decode_inst (.clk_in, .reset_n_in, .core_req_in,
    .debug_req_in, .prog_master_in, .dev_mode_in, .core_pc_in,
    .port1_irq_event_in, .region_rdata_in, .boot_vector_out,
    .core_ready_out, .debug_ready_out, .rdata_out, .slverr_out,
    .region_out(), .periph_out(), .region_sel_out(), .region_write_out(),
    .region_addr_out(), .region_wdata_out(), .byte_en_out(),
    .port1_irq_enable_out(), .port1_irq_flag_out(), .bp_full_sets_out,
    .bp_simple_regs_out);

  function automatic logic [15:0] next_val(input logic [15:0] o,
                                           input logic [31:0] w);
    return {(o[15:8] & ~w[31:24]) | (w[23:16] & w[31:24]),
            (o[7:0] & ~w[15:8]) | (w[7:0] & w[15:8])};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    errors += core_master_inst.late + debug_master_inst.late;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic readback;
    core_master_inst.xfer(1'b0, 20'h40010, 32'h00000000);
    check(rdata_out, {8'h00, model[15:8], 8'h00, model[7:0]});
  endtask

  task automatic touch(input logic [31:0] d);
    core_master_inst.xfer(1'b1, 20'h40010, d);
    model = next_val(model, d);
    readback();
  endtask

  // a stalled handshake ends the run at once
  always @(posedge clk_in) begin
    if (core_master_inst.late + debug_master_inst.late > 0) close_out();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    reset_n_in = 1'b1;
    check(boot_vector_out, 32'h00080000);
    check({24'h0, bp_full_sets_out, bp_simple_regs_out}, 32'h26);
    readback();
    touch(32'h00003F2A);
    touch(32'hFF000000);
    for (int i = 0; i < 24; i++) touch($random(seed));
    // pin event sets flags; held one cycle, seen after the two sync flops
    port1_irq_event_in = 8'h81;
    @(negedge clk_in);
    port1_irq_event_in = 8'h00;
    model[7:0] = model[7:0] | 8'h81;
    repeat (2) @(negedge clk_in);
    readback();
    for (int i = 0; i < 8; i++) begin
      region_rdata_in = $random(seed);
      core_master_inst.size = 2'(i % 3);
      core_master_inst.xfer(1'b0, addrs[i], 32'h00000000);
      if (i < 7) check(rdata_out, region_rdata_in);
      check({31'h0, slverr_out}, {31'h0, i == 7});
    end
    core_master_inst.size = 2'h2;
    core_master_inst.xfer(1'b1, 20'h80000, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      dev_mode_in = i[2];
      core_pc_in = i[1] ? 32'h00080010 : 32'h00090000;
      prog_master_in = i[0];
      core_master_inst.xfer(1'b0, 20'hD0000, 32'h00000000);
      check({31'h0, slverr_out}, {31'h0, !(i[2] && i[1:0] != 2'h0)});
    end
    prog_master_in = 1'b0;
    core_pc_in = 32'h00090000;
    debug_master_inst.xfer(1'b0, 20'hD03FF, 32'h00000000);
    check({31'h0, slverr_out}, 32'h00000000);
    dev_mode_in = 1'b0;
    debug_master_inst.xfer(1'b0, 20'hD0000, 32'h00000000);
    check({31'h0, slverr_out}, 32'h00000001);
    fork
      debug_master_inst.xfer(1'b1, 20'h40010, 32'hFF5A0000);
      core_master_inst.xfer(1'b1, 20'h40010, 32'hFFA50000);
    join
    model = next_val(next_val(model, 32'hFF5A0000), 32'hFFA50000);
    readback();
    close_out();
  end
endmodule
